// file: hw/cpa_charge_regs.sv
// charge phase control, phase timers, status indicators and limit alerts
`timescale 1ns/1ps
// Function
// - absorb target from adders, step, base, N
// - absorb target clamped at N times 7.8V
// - absorb adder six bits, resets to 21
// - zero absorb adder skips absorb phase
// - absorb temp comp minus 11mV per degree
// - absorb limit 16 bits, resets 5400 seconds
// - absorb timer ends absorb when exceeding limit
// - equalize target from adders, step, base, N
// - equalize temp comp minus 11.4mV per degree
// - equalize adder resets 42, clamped 7.8V
// - equalize limit 3600, timer reaching ends equalize
// - one-hot phase indicator, suspended after reset
// - one-hot regulation status only while charging
// - alert sets only when enabled, sticky
// - write zero clears only that alert
// - clearing enable clears latched alert
// - bit 15 flags measurement warm-up done
// - bit 14 flags resistance measurement done
// - threshold alerts on bits 11 down to 4
// - equalize request runs after absorb, self-clears
// - low battery current ends absorb early
// - writing zero request cancels equalize
module cpa_charge_regs #(
  parameter int         TICK_CYCLES = cpa_pkg::TICK_CYCLES,
  parameter logic [6:0] DEV_ADDR    = 7'h2A  // arbitrary value
) (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RSTN_IN,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_OUT,
  input  wire logic [1:0]  CELL_GROUPS_IN,
  input  wire logic [7:0]  TEMP_C_IN,
  input  wire logic        SUSPEND_IN,
  input  wire logic        BAT_SHORT_IN,
  input  wire logic        BAT_MISSING_IN,
  input  wire logic        DETECT_FAILED_IN,
  input  wire logic        DETECTING_IN,
  input  wire logic        VOLTAGE_REACHED_IN,
  input  wire logic        BATTERY_CURRENT_LOW_IN,
  input  wire logic [5:0]  REG_LOOP_IN,
  input  wire logic [15:0] ALERT_ENABLE_IN,
  input  wire logic [15:0] ALERT_COND_IN,
  output logic [24:0]      TARGET_UV_OUT,
  output logic [12:0]      PHASE_OUT,
  output logic [5:0]       REG_STATUS_OUT,
  output logic [15:0]      ALERT_FLAGS_OUT
);
  localparam int TW = $clog2(TICK_CYCLES);

  cpa_reg_if rif ();

  logic [5:0]          vcharge_r;
  logic [5:0]          abs_add_r;
  logic [15:0]         abs_lim_r;
  logic [5:0]          eq_add_r;
  logic [15:0]         eq_lim_r;
  logic                eq_req_r;
  logic                temp_comp_r;
  logic [15:0]         abs_tmr_r;
  logic [15:0]         eq_tmr_r;
  logic [15:0]         alert_r;
  logic [15:0]         alert_nxt;
  logic [15:0]         alert_clr;
  cpa_pkg::cpa_phase_t phase_r;
  cpa_pkg::cpa_phase_t phase_nxt;
  logic                absorbed_r;
  logic                absorbed_nxt;
  logic                eq_done;
  logic [TW-1:0]       tick_cnt_r;
  logic                tick_r;
  logic                charging;
  logic [22:0]         cell_uv;
  logic [15:0]         rdata;
  logic                sda_low_r;

  // per-cell target, clamped to the hardware ceiling
  function automatic logic [22:0] cell_target(input logic [6:0] code,
                                              input int tc_uv,
                                              input logic [7:0] temp_c);
    int v;
    v = int'(code) * cpa_pkg::STEP_UV + cpa_pkg::BASE_UV;
    v = v - tc_uv * (int'($signed(temp_c)) - cpa_pkg::REF_TEMP_C);
    if (v > cpa_pkg::CELL_MAX_UV) begin
      v = cpa_pkg::CELL_MAX_UV;
    end
    if (v < 0) begin
      v = 0;
    end
    return v[22:0];
  endfunction

  // keeps the reported loop one-hot when several loops are active
  function automatic logic [5:0] highest_bit(input logic [5:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < 6; i++) begin
      if (v[i]) begin
        r = 6'h01 << i;
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == cpa_pkg::TMR_MAX) ? v : v + 16'h0001;
  endfunction

  cpa_i2c_port #(
    .DEV_ADDR (DEV_ADDR)
  ) u_port (
    .clk_in     (SYS_CLK_IN),
    .rstn_in    (RSTN_IN),
    .scl_in     (SCL_IN),
    .sda_in     (SDA_IN),
    .sda_oe_out (SDA_OE_OUT),
    .rif        (rif.port)
  );

  // open drain: the pin is only ever pulled low
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      sda_low_r <= 1'b0;
    end else begin
      sda_low_r <= 1'b0;
    end
  end
  assign SDA_OUT = sda_low_r;

  // one second tick divider
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + TW'(1);
      tick_r <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      vcharge_r <= cpa_pkg::RST_VCHARGE;
      abs_add_r <= cpa_pkg::RST_ABS_ADD;
      abs_lim_r <= cpa_pkg::RST_ABS_LIM;
      eq_add_r <= cpa_pkg::RST_EQ_ADD;
      eq_lim_r <= cpa_pkg::RST_EQ_LIM;
      temp_comp_r <= cpa_pkg::RST_CONFIG[cpa_pkg::CFG_TEMP_COMP_BIT];
    end else if (rif.wr_stb) begin
      unique case (rif.cmd)
        cpa_pkg::OFS_VCHARGE: vcharge_r <= rif.wdata[5:0];
        cpa_pkg::OFS_ABS_ADD: abs_add_r <= rif.wdata[5:0];
        cpa_pkg::OFS_ABS_LIM: abs_lim_r <= rif.wdata;
        cpa_pkg::OFS_EQ_ADD:  eq_add_r <= rif.wdata[5:0];
        cpa_pkg::OFS_EQ_LIM:  eq_lim_r <= rif.wdata;
        cpa_pkg::OFS_CONFIG:  temp_comp_r <= rif.wdata[cpa_pkg::CFG_TEMP_COMP_BIT];
        default: ;
      endcase
    end
  end

  // equalize request; a host write of one beats the self clear
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      eq_req_r <= cpa_pkg::RST_CONFIG[cpa_pkg::CFG_EQ_REQ_BIT];
    end else if (rif.wr_stb && rif.cmd == cpa_pkg::OFS_CONFIG) begin
      eq_req_r <= rif.wdata[cpa_pkg::CFG_EQ_REQ_BIT];
    end else if (eq_done || SUSPEND_IN) begin
      eq_req_r <= 1'b0;
    end
  end

  assign charging = (phase_r == cpa_pkg::PH_BULK) || (phase_r == cpa_pkg::PH_ABSORB) ||
                    (phase_r == cpa_pkg::PH_EQUALIZE);

  // phase sequencing; faults and suspension override the charge cycle
  always_comb begin
    phase_nxt = phase_r;
    absorbed_nxt = absorbed_r;
    eq_done = 1'b0;
    if (SUSPEND_IN) begin
      phase_nxt = cpa_pkg::PH_SUSPEND;
      absorbed_nxt = 1'b0;
    end else if (BAT_SHORT_IN) begin
      phase_nxt = cpa_pkg::PH_SHORT;
      absorbed_nxt = 1'b0;
    end else if (BAT_MISSING_IN) begin
      phase_nxt = cpa_pkg::PH_MISSING;
      absorbed_nxt = 1'b0;
    end else if (DETECT_FAILED_IN) begin
      phase_nxt = cpa_pkg::PH_DET_FAIL;
      absorbed_nxt = 1'b0;
    end else if (DETECTING_IN) begin
      phase_nxt = cpa_pkg::PH_DETECT;
      absorbed_nxt = 1'b0;
    end else begin
      unique case (phase_r)
        cpa_pkg::PH_ABSORB: begin
          // absorb ends on time or low current
          if (abs_tmr_r > abs_lim_r || BATTERY_CURRENT_LOW_IN) begin
            absorbed_nxt = 1'b1;
            phase_nxt = eq_req_r ? cpa_pkg::PH_EQUALIZE : cpa_pkg::PH_BULK;
          end
        end
        cpa_pkg::PH_EQUALIZE: begin
          if (!eq_req_r) begin
            phase_nxt = cpa_pkg::PH_BULK;
          // equalize ends when timer reaches limit
          end else if (eq_tmr_r >= eq_lim_r) begin
            phase_nxt = cpa_pkg::PH_BULK;
            eq_done = 1'b1;
          end
        end
        cpa_pkg::PH_BULK: begin
          if (VOLTAGE_REACHED_IN && !absorbed_r) begin
            if (abs_add_r != 6'h00) begin
              phase_nxt = cpa_pkg::PH_ABSORB;
            end else begin
              absorbed_nxt = 1'b1;
              phase_nxt = eq_req_r ? cpa_pkg::PH_EQUALIZE : cpa_pkg::PH_BULK;
            end
          end
        end
        cpa_pkg::PH_SUSPEND, cpa_pkg::PH_SHORT, cpa_pkg::PH_MISSING,
        cpa_pkg::PH_DET_FAIL, cpa_pkg::PH_DETECT: begin
          phase_nxt = cpa_pkg::PH_BULK;
          absorbed_nxt = 1'b0;
        end
        default: phase_nxt = cpa_pkg::PH_SUSPEND;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      phase_r <= cpa_pkg::PH_SUSPEND;
      absorbed_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      absorbed_r <= absorbed_nxt;
    end
  end

  // timers zero on entry, count ticks, saturate
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      abs_tmr_r <= 16'h0000;
      eq_tmr_r <= 16'h0000;
    end else begin
      if (phase_r != cpa_pkg::PH_ABSORB && phase_nxt == cpa_pkg::PH_ABSORB) begin
        abs_tmr_r <= 16'h0000;
      end else if (phase_r == cpa_pkg::PH_ABSORB && tick_r) begin
        abs_tmr_r <= sat_inc(abs_tmr_r);
      end
      if (phase_r != cpa_pkg::PH_EQUALIZE && phase_nxt == cpa_pkg::PH_EQUALIZE) begin
        eq_tmr_r <= 16'h0000;
      end else if (phase_r == cpa_pkg::PH_EQUALIZE && tick_r) begin
        eq_tmr_r <= sat_inc(eq_tmr_r);
      end
    end
  end

  // bulk charging runs at the plain charge setting
  always_comb begin
    unique case (phase_r)
      cpa_pkg::PH_ABSORB:
        cell_uv = cell_target({1'b0, vcharge_r} + {1'b0, abs_add_r},
                              temp_comp_r ? cpa_pkg::ABS_TC_UV : 0, TEMP_C_IN);
      cpa_pkg::PH_EQUALIZE:
        cell_uv = cell_target({1'b0, vcharge_r} + {1'b0, eq_add_r},
                              temp_comp_r ? cpa_pkg::EQ_TC_UV : 0, TEMP_C_IN);
      cpa_pkg::PH_BULK:
        cell_uv = cell_target({1'b0, vcharge_r}, 0, TEMP_C_IN);
      default: cell_uv = 23'h000000;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      TARGET_UV_OUT <= 25'h0000000;
    end else begin
      TARGET_UV_OUT <= 25'({2'b00, CELL_GROUPS_IN} + 4'h1) * {2'b00, cell_uv};
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      REG_STATUS_OUT <= 6'h00;
    end else begin
      REG_STATUS_OUT <= charging ? highest_bit(REG_LOOP_IN) : 6'h00;
    end
  end

  // only bits written as zero are cleared
  assign alert_clr = (rif.wr_stb && rif.cmd == cpa_pkg::OFS_ALERT) ? ~rif.wdata : 16'h0000;

  assign alert_nxt = ((alert_r & ~alert_clr) | ALERT_COND_IN) & ALERT_ENABLE_IN & cpa_pkg::ALERT_MASK;

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      alert_r <= 16'h0000;
    end else begin
      alert_r <= alert_nxt;
    end
  end

  assign ALERT_FLAGS_OUT = alert_r;
  assign PHASE_OUT = phase_r;

  // unmapped codes read as zero
  always_comb begin
    unique case (rif.cmd)
      cpa_pkg::OFS_VCHARGE: rdata = {10'h000, vcharge_r};
      cpa_pkg::OFS_CONFIG:  rdata = {14'h0000, temp_comp_r, eq_req_r};
      cpa_pkg::OFS_ABS_ADD: rdata = {10'h000, abs_add_r};
      cpa_pkg::OFS_ABS_LIM: rdata = abs_lim_r;
      cpa_pkg::OFS_EQ_ADD:  rdata = {10'h000, eq_add_r};
      cpa_pkg::OFS_EQ_LIM:  rdata = eq_lim_r;
      cpa_pkg::OFS_ABS_TMR: rdata = abs_tmr_r;
      cpa_pkg::OFS_EQ_TMR:  rdata = eq_tmr_r;
      cpa_pkg::OFS_PHASE:   rdata = {3'h0, phase_r};
      cpa_pkg::OFS_REG_ST:  rdata = {10'h000, REG_STATUS_OUT};
      cpa_pkg::OFS_ALERT:   rdata = alert_r;
      default:              rdata = 16'h0000;
    endcase
  end
  assign rif.rdata = rdata;
endmodule

// file: hw/cpa_pkg.sv
// constants shared by the charge phase register bank and its serial port
package cpa_pkg;
  // command codes
  localparam logic [7:0] OFS_VCHARGE = 8'h1B;
  localparam logic [7:0] OFS_CONFIG = 8'h29;
  localparam logic [7:0] OFS_ABS_ADD = 8'h2A;
  localparam logic [7:0] OFS_ABS_LIM = 8'h2B;
  localparam logic [7:0] OFS_EQ_ADD = 8'h2C;
  localparam logic [7:0] OFS_EQ_LIM = 8'h2D;
  localparam logic [7:0] OFS_ABS_TMR = 8'h32;
  localparam logic [7:0] OFS_EQ_TMR = 8'h33;
  localparam logic [7:0] OFS_PHASE = 8'h34;
  localparam logic [7:0] OFS_REG_ST = 8'h35;
  localparam logic [7:0] OFS_ALERT = 8'h36;
  // values after reset
  localparam logic [5:0] RST_VCHARGE = 6'h15;
  localparam logic [5:0] RST_ABS_ADD = 6'h15;
  localparam logic [15:0] RST_ABS_LIM = 16'h1518;
  localparam logic [5:0] RST_EQ_ADD = 6'h2A;
  localparam logic [15:0] RST_EQ_LIM = 16'h0E10;
  localparam logic [1:0] RST_CONFIG = 2'h2;
  // config field positions
  localparam int CFG_EQ_REQ_BIT = 0;
  localparam int CFG_TEMP_COMP_BIT = 1;
  // implemented limit alert bits: 15, 14, 11..0
  localparam logic [15:0] ALERT_MASK = 16'hCFFF;
  // voltage arithmetic, in microvolts per cell
  localparam int STEP_UV = 28571;
  localparam int BASE_UV = 6000000;
  localparam int CELL_MAX_UV = 7800000;
  localparam int ABS_TC_UV = 11000;
  localparam int EQ_TC_UV = 11400;
  localparam int REF_TEMP_C = 25;
  // one second tick
  localparam int CLK_HZ = 25000000;
  localparam int TICK_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;
  localparam logic [15:0] TMR_MAX = 16'hFFFF;
  // serial port
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] IDX_WR_HI = 2'h3;

  typedef enum logic [12:0] {
    PH_DET_FAIL = 13'h1000,
    PH_DETECT   = 13'h0800,
    PH_EQUALIZE = 13'h0400,
    PH_ABSORB   = 13'h0200,
    PH_SUSPEND  = 13'h0100,
    PH_BULK     = 13'h0040,
    PH_MISSING  = 13'h0002,
    PH_SHORT    = 13'h0001
  } cpa_phase_t;

  typedef enum logic [2:0] {
    SP_IDLE = 3'b000,
    SP_RX   = 3'b001,
    SP_ACK  = 3'b010,
    SP_TX   = 3'b011,
    SP_MACK = 3'b100
  } cpa_sp_state_t;
endpackage

// file: hw/cpa_reg_if.sv
// register access carrier between serial port engine and register bank
`timescale 1ns/1ps
interface cpa_reg_if;
  logic [7:0]  cmd;
  logic [15:0] wdata;
  logic        wr_stb;
  logic [15:0] rdata;
  modport port (output cmd, output wdata, output wr_stb, input rdata);
  modport bank (input cmd, input wdata, input wr_stb, output rdata);
endinterface

// file: hw/cpa_i2c_port.sv
// two-wire serial slave: command code then 16-bit word, low byte first
`timescale 1ns/1ps
module cpa_i2c_port #(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // arbitrary value
) (
  input  wire logic  clk_in,
  input  wire logic  rstn_in,
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  output logic       sda_oe_out,
  cpa_reg_if.port    rif
);
  logic scl_r, scl_p, sda_r, sda_p;
  logic start, stop, rise, fall;
  cpa_pkg::cpa_sp_state_t st_r;
  logic [3:0] bcnt_r;
  logic [1:0] idx_r;
  logic [7:0] sh_r, lo_r, tx_r, hold_r;
  logic       rw_r, acked_r;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_r <= 1'b1;
      scl_p <= 1'b1;
      sda_r <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_r <= scl_in;
      scl_p <= scl_r;
      sda_r <= sda_in;
      sda_p <= sda_r;
    end
  end

  assign start = scl_r & scl_p & sda_p & ~sda_r;
  assign stop  = scl_r & scl_p & ~sda_p & sda_r;
  assign rise  = scl_r & ~scl_p;
  assign fall  = ~scl_r & scl_p;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= cpa_pkg::SP_IDLE;
      bcnt_r <= 4'h0;
      idx_r <= 2'h0;
      sh_r <= 8'h00;
      lo_r <= 8'h00;
      tx_r <= 8'h00;
      hold_r <= 8'h00;
      rw_r <= 1'b0;
      acked_r <= 1'b0;
      sda_oe_out <= 1'b0;
      rif.cmd <= 8'h00;
      rif.wdata <= 16'h0000;
      rif.wr_stb <= 1'b0;
    end else begin
      rif.wr_stb <= 1'b0;
      if (start) begin
        st_r <= cpa_pkg::SP_RX;
        bcnt_r <= 4'h0;
        idx_r <= 2'h0;
        sda_oe_out <= 1'b0;
      end else if (stop) begin
        st_r <= cpa_pkg::SP_IDLE;
        sda_oe_out <= 1'b0;
      end else begin
        unique case (st_r)
          cpa_pkg::SP_IDLE: ;
          cpa_pkg::SP_RX: begin
            if (rise) begin
              sh_r <= {sh_r[6:0], sda_r};
              bcnt_r <= bcnt_r + 4'h1;
            end else if (fall && bcnt_r == cpa_pkg::BITS_PER_BYTE) begin
              sda_oe_out <= 1'b1;
              st_r <= cpa_pkg::SP_ACK;
              if (idx_r != cpa_pkg::IDX_WR_HI) begin
                idx_r <= idx_r + 2'h1;
              end
              unique case (idx_r)
                2'h0: begin
                  rw_r <= sh_r[0];
                  // not our address: stay off the line until next start
                  if (sh_r[7:1] != DEV_ADDR) begin
                    sda_oe_out <= 1'b0;
                    st_r <= cpa_pkg::SP_IDLE;
                  end
                end
                2'h1: rif.cmd <= sh_r;
                2'h2: lo_r <= sh_r;
                2'h3: begin
                  rif.wdata <= {sh_r, lo_r};
                  rif.wr_stb <= 1'b1;
                end
              endcase
            end
          end
          cpa_pkg::SP_ACK: begin
            if (fall) begin
              bcnt_r <= 4'h0;
              if (rw_r) begin
                tx_r <= rif.rdata[7:0];
                hold_r <= rif.rdata[15:8];
                sda_oe_out <= ~rif.rdata[7];
                st_r <= cpa_pkg::SP_TX;
              end else begin
                sda_oe_out <= 1'b0;
                st_r <= cpa_pkg::SP_RX;
              end
            end
          end
          cpa_pkg::SP_TX: begin
            if (fall) begin
              bcnt_r <= bcnt_r + 4'h1;
              tx_r <= {tx_r[6:0], 1'b0};
              if (bcnt_r == cpa_pkg::BITS_PER_BYTE - 4'h1) begin
                sda_oe_out <= 1'b0;
                acked_r <= 1'b0;
                st_r <= cpa_pkg::SP_MACK;
              end else begin
                sda_oe_out <= ~tx_r[6];
              end
            end
          end
          cpa_pkg::SP_MACK: begin
            if (rise) begin
              acked_r <= ~sda_r;
              if (sda_r) begin
                st_r <= cpa_pkg::SP_IDLE;
              end
            end else if (fall && acked_r) begin
              // bytes past the high byte read as zero
              tx_r <= hold_r;
              hold_r <= 8'h00;
              sda_oe_out <= ~hold_r[7];
              bcnt_r <= 4'h0;
              st_r <= cpa_pkg::SP_TX;
            end
          end
          default: st_r <= cpa_pkg::SP_IDLE;
        endcase
      end
    end
  end
endmodule

// file: test/cpa_host_model.sv
// two-wire host model issuing register writes and reads
`timescale 1ns/1ps
module cpa_host_model #(
  parameter logic [6:0] ADDR = 7'h2A  // arbitrary value
) (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // half period of five clocks, above the four-clock minimum
  task automatic hp();
    repeat (5) @(negedge clk_in);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = ~b;
    hp();
    scl_out = 1'b1;
    hp();
    r = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic start();
    sda_low_out = 1'b0;
    hp();
    scl_out = 1'b1;
    hp();
    sda_low_out = 1'b1;
    hp();
    scl_out = 1'b0;
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    hp();
    scl_out = 1'b1;
    hp();
    sda_low_out = 1'b0;
    hp();
  endtask
  // ack_bit 1 releases the line so the device can acknowledge
  task automatic xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_bit, a);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2, a3;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, a0);
    xfer(c, 1'b1, q, a1);
    xfer(d[7:0], 1'b1, q, a2);
    xfer(d[15:8], 1'b1, q, a3);
    stop();
    ok = ~(a0 | a1 | a2 | a3);
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2, a3;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, a0);
    xfer(c, 1'b1, q, a1);
    start();
    xfer({ADDR, 1'b1}, 1'b1, q, a2);
    xfer(8'hFF, 1'b0, d[7:0], a3);
    xfer(8'hFF, 1'b1, d[15:8], a3);
    stop();
    ok = ~(a0 | a1 | a2);
  endtask
endmodule

// file: test/cpa_charge_regs_chk.sv
// port checker for the charge phase register bank
`timescale 1ns/1ps
module cpa_charge_regs_chk (
  input wire logic        SYS_CLK_IN,
  input wire logic        RSTN_IN,
  input wire logic        SUSPEND_IN,
  input wire logic        BAT_SHORT_IN,
  input wire logic        BATTERY_CURRENT_LOW_IN,
  input wire logic [15:0] ALERT_ENABLE_IN,
  input wire logic [15:0] ALERT_COND_IN,
  input wire logic [12:0] PHASE_OUT,
  input wire logic [5:0]  REG_STATUS_OUT,
  input wire logic [15:0] ALERT_FLAGS_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  chk_phase_onehot: assert property ($onehot(PHASE_OUT))
    else $error("phase indicator not one-hot");
  chk_status_onehot: assert property ($onehot0(REG_STATUS_OUT))
    else $error("loop status has several bits");
  chk_status_idle: assert property (
    (!(PHASE_OUT inside {cpa_pkg::PH_BULK, cpa_pkg::PH_ABSORB, cpa_pkg::PH_EQUALIZE}))[*2]
      |-> REG_STATUS_OUT == 6'h00)
    else $error("loop status outside charging");
  chk_suspend_phase: assert property (SUSPEND_IN |=> PHASE_OUT == cpa_pkg::PH_SUSPEND)
    else $error("suspend not shown");
  chk_short_phase: assert property (!SUSPEND_IN && BAT_SHORT_IN |=> PHASE_OUT == cpa_pkg::PH_SHORT)
    else $error("short fault not shown");
  chk_absorb_lowcur: assert property (
    PHASE_OUT == cpa_pkg::PH_ABSORB && BATTERY_CURRENT_LOW_IN |-> ##[1:2] PHASE_OUT != cpa_pkg::PH_ABSORB)
    else $error("absorb kept at low current");
  chk_alert_set: assert property (
    |(ALERT_COND_IN & ALERT_ENABLE_IN & cpa_pkg::ALERT_MASK) |=>
      (ALERT_FLAGS_OUT & $past(ALERT_COND_IN & ALERT_ENABLE_IN & cpa_pkg::ALERT_MASK))
        == $past(ALERT_COND_IN & ALERT_ENABLE_IN & cpa_pkg::ALERT_MASK))
    else $error("enabled alert not latched");
  chk_alert_gate: assert property (
    (ALERT_FLAGS_OUT & ~$past(ALERT_FLAGS_OUT) & ~$past(ALERT_COND_IN & ALERT_ENABLE_IN)) == 16'h0000)
    else $error("alert set without enabled cause");
  chk_alert_enoff: assert property ((ALERT_FLAGS_OUT & ~$past(ALERT_ENABLE_IN)) == 16'h0000)
    else $error("alert kept after enable cleared");
  chk_alert_unused: assert property ((ALERT_FLAGS_OUT & ~cpa_pkg::ALERT_MASK) == 16'h0000)
    else $error("unimplemented alert bit set");
  cov_absorb: cover property (PHASE_OUT == cpa_pkg::PH_ABSORB ##1 PHASE_OUT == cpa_pkg::PH_EQUALIZE);
  cov_eq_end: cover property (PHASE_OUT == cpa_pkg::PH_EQUALIZE ##1 PHASE_OUT == cpa_pkg::PH_BULK);
  cov_alert: cover property (ALERT_FLAGS_OUT == cpa_pkg::ALERT_MASK);
endmodule
bind cpa_charge_regs cpa_charge_regs_chk i_cpa_charge_regs_chk (
  .SYS_CLK_IN(SYS_CLK_IN),
  .RSTN_IN(RSTN_IN),
  .SUSPEND_IN(SUSPEND_IN),
  .BAT_SHORT_IN(BAT_SHORT_IN),
  .BATTERY_CURRENT_LOW_IN(BATTERY_CURRENT_LOW_IN),
  .ALERT_ENABLE_IN(ALERT_ENABLE_IN),
  .ALERT_COND_IN(ALERT_COND_IN),
  .PHASE_OUT(PHASE_OUT),
  .REG_STATUS_OUT(REG_STATUS_OUT),
  .ALERT_FLAGS_OUT(ALERT_FLAGS_OUT)
);

// file: test/cpa_charge_regs_test.sv
// self-checking bench for the charge phase register bank
`timescale 1ns/1ps
module cpa_charge_regs_test;
  logic        clk, rstn, scl, m_low, sda, sda_o, sda_oe, ok, susp, vreach, ilow;
  logic [3:0]  flt;
  logic [1:0]  cells;
  logic [7:0]  temp;
  logic [5:0]  loops, st;
  logic [15:0] en, cond, q, alr;
  logic [24:0] tgt;
  logic [12:0] ph;
  int          error_cnt, total_checks, n;
  logic [7:0]  rc [9] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h32, 8'h33, 8'h35, 8'h36, 8'h40};
  logic [15:0] rv [9] = '{16'h0015, 16'h1518, 16'h002A, 16'h0E10, 16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0000};
  logic [12:0] pc [4] = '{13'h0001, 13'h0002, 13'h1000, 13'h0800};
  // open drain line with pull-up
  assign sda = (sda_oe ? sda_o : 1'b1) & ~m_low;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  cpa_host_model i_cpa_host_model (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(m_low));
  cpa_charge_regs #(.TICK_CYCLES(20)) i_cpa_charge_regs (
    .SYS_CLK_IN(clk), .RSTN_IN(rstn), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe),
    .CELL_GROUPS_IN(cells), .TEMP_C_IN(temp), .SUSPEND_IN(susp), .BAT_SHORT_IN(flt[0]),
    .BAT_MISSING_IN(flt[1]), .DETECT_FAILED_IN(flt[2]), .DETECTING_IN(flt[3]),
    .VOLTAGE_REACHED_IN(vreach), .BATTERY_CURRENT_LOW_IN(ilow), .REG_LOOP_IN(loops),
    .ALERT_ENABLE_IN(en), .ALERT_COND_IN(cond), .TARGET_UV_OUT(tgt), .PHASE_OUT(ph),
    .REG_STATUS_OUT(st), .ALERT_FLAGS_OUT(alr));
  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    i_cpa_host_model.rd(c, q, ok);
    chk({ok, q}, {1'b1, e});
  endtask
  task automatic wrr(input logic [7:0] c, input logic [15:0] d);
    i_cpa_host_model.wr(c, d, ok);
    chk(ok, 1'b1);
  endtask
  task automatic waitph(input logic [12:0] p, input int lim);
    n = 0;
    while (ph !== p && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) begin
      error_cnt++;
      results();
    end
  endtask
  // per-cell microvolts, clamped at 7.8V, times N
  function automatic logic [31:0] exp_uv(input int s, input int nc, input int dt);
    int v;
    v = s * 28571 + 6000000 - dt;
    if (v > 7800000) v = 7800000;
    return v * nc;
  endfunction
  initial begin
    {rstn, susp, vreach, ilow, flt, cells, en, cond} = '0;
    temp = 8'h19;
    loops = 6'h03;
    repeat (15) @(negedge clk);
    chk(ph, 13'h0100);
    @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    foreach (rc[i]) rdc(rc[i], rv[i]);
    wrr(8'h32, 16'h1234);
    rdc(8'h32, 16'h0000);
    wrr(8'h2B, 16'h0028);
    rdc(8'h2B, 16'h0028);
    wrr(8'h2D, 16'h001E);
    wrr(8'h29, 16'h0003);
    cells = 2'h1;
    vreach = 1'b1;
    waitph(13'h0200, 20);
    repeat (3) @(negedge clk);
    chk(tgt, exp_uv(42, 2, 0));
    temp = 8'h23;
    repeat (3) @(negedge clk);
    chk(tgt, exp_uv(42, 2, 110000));
    temp = 8'h19;
    waitph(13'h0400, 900);
    chk(n inside {[780:830]}, 1'b1);
    // target follows the phase one cycle later
    @(negedge clk);
    chk(tgt, exp_uv(63, 2, 0));
    temp = 8'h23;
    repeat (3) @(negedge clk);
    chk(tgt, exp_uv(63, 2, 114000));
    waitph(13'h0040, 700);
    chk(n inside {[560:610]}, 1'b1);
    rdc(8'h29, 16'h0002);
    wrr(8'h2A, 16'h003F);
    susp = 1'b1;
    repeat (2) @(negedge clk);
    chk(ph, 13'h0100);
    susp = 1'b0;
    temp = 8'h19;
    waitph(13'h0200, 20);
    repeat (3) @(negedge clk);
    chk(tgt, exp_uv(84, 2, 0));
    ilow = 1'b1;
    waitph(13'h0040, 4);
    ilow = 1'b0;
    wrr(8'h2A, 16'h0000);
    susp = 1'b1;
    repeat (2) @(negedge clk);
    susp = 1'b0;
    repeat (6) @(negedge clk);
    chk(ph, 13'h0040);
    // request stays across faults, so the next pass equalizes
    wrr(8'h29, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      flt = 4'h1 << i;
      repeat (3) @(negedge clk);
      chk({st, ph}, {6'h00, pc[i]});
    end
    flt = 4'h0;
    waitph(13'h0400, 20);
    chk(ph, 13'h0400);
    wrr(8'h29, 16'h0002);
    chk(ph, 13'h0040);
    en = 16'hFFFF;
    cond = 16'hFFFF;
    @(negedge clk);
    cond = 16'h0000;
    chk(alr[15:14], 2'h3);
    rdc(8'h36, 16'hCFFF);
    wrr(8'h36, 16'hFBFF);
    rdc(8'h36, 16'hCBFF);
    chk(alr, 16'hCBFF);
    en[15] = 1'b0;
    rdc(8'h36, 16'h4BFF);
    en = 16'h0000;
    cond = 16'h0010;
    @(negedge clk);
    cond = 16'h0000;
    rdc(8'h36, 16'h0000);
    results();
  end
endmodule
